// ===== pkg/sensor_twowire_pkg.sv
package sensor_twowire_pkg;

    // ==========================================
    // Geometry
    localparam int          REG_COUNT        = 128;
    localparam int          IDX_W            = 7;
    localparam logic [2:0]  POWERUP_FIELDS_V = 3'd4;

    // ==========================================
    // Bus address and identity
    localparam logic [6:0]  DEVICE_ADDR      = 7'h20;
    // Arbitrary identity values
    localparam logic [7:0]  ID_HIGH          = 8'h5a;
    localparam logic [7:0]  ID_LOW           = 8'h3c;
    localparam logic [7:0]  UNUSED_BYTE      = 8'h19;

    // ==========================================
    // Register indexes
    localparam logic [6:0]  IDX_STATUS0      = 7'h02;
    localparam logic [6:0]  IDX_XEND_H       = 7'h05;
    localparam logic [6:0]  IDX_XEND_L       = 7'h06;
    localparam logic [6:0]  IDX_YEND_H       = 7'h07;
    localparam logic [6:0]  IDX_YEND_L       = 7'h08;
    localparam logic [6:0]  STATUS_LAST      = 7'h0d;
    localparam logic [6:0]  IDX_POWER_TIMING_SETUP       = 7'h10;
    localparam logic [6:0]  IDX_SETUP1       = 7'h11;
    localparam logic [6:0]  IDX_SYNC_VALUE   = 7'h12;
    localparam logic [6:0]  IDX_RESERVED     = 7'h13;
    localparam logic [6:0]  IDX_PIN_MAPPING  = 7'h15;
    localparam logic [6:0]  IDX_DATA_FORMAT  = 7'h16;
    localparam logic [6:0]  FIRST_RW_INDEX   = 7'h10;

    // ==========================================
    // Field positions
    localparam int          LOW_POWER_BIT    = 0;
    localparam int          SOFT_RESET_BIT   = 2;

    // ==========================================
    // Reset values
    localparam logic [7:0]  STATUS0_DEFAULT  = 8'h10;
    localparam logic [7:0]  XEND_H_VALUE     = 8'h01;
    localparam logic [7:0]  XEND_L_VALUE     = 8'h67;
    localparam logic [7:0]  YEND_H_VALUE     = 8'h01;
    localparam logic [7:0]  YEND_L_VALUE     = 8'h25;
    localparam logic [7:0]  POWER_TIMING_SETUP_DEFAULT   = 8'h09;
    localparam logic [7:0]  SETUP1_DEFAULT   = 8'hc0;
    localparam logic [7:0]  SYNC_DEFAULT     = 8'h1f;
    localparam logic [7:0]  PIN_MAP_DEFAULT  = 8'h08;
    localparam logic [7:0]  FORMAT_DEFAULT   = 8'h08;

    // ==========================================
    // Protocol states
    typedef enum logic [3:0]
    {
        ST_IDLE,
        ST_ADDR,
        ST_ACK_ADDR,
        ST_INDEX,
        ST_ACK_INDEX,
        ST_WDATA,
        ST_ACK_DATA,
        ST_TX,
        ST_MACK,
        ST_IGNORE
    } state_t;

endpackage

// ===== pkg/twowire_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface twowire_link_if;
    logic sampled_bit;
    logic edge_toggle;

    modport sampler
    (
        output sampled_bit,
        output edge_toggle
    );

    modport consumer
    (
        input  sampled_bit,
        input  edge_toggle
    );
endinterface

`default_nettype wire

// ===== design/twowire_bit_sampler.sv
`timescale 1ns/1ps
`default_nettype none

module twowire_bit_sampler
(
    input  wire logic        scl,
    input  wire logic        rst,
    input  wire logic        sda_in,
    twowire_link_if.sampler  link
);

    // ==========================================
    // Data sampled on each rising serial clock
    always_ff @(posedge scl or posedge rst)
    begin
        if (rst)
        begin
            link.sampled_bit <= 1'b0;
            link.edge_toggle <= 1'b0;
        end
        else
        begin
            link.sampled_bit <= sda_in; // R2
            link.edge_toggle <= ~link.edge_toggle;
        end
    end

endmodule

`default_nettype wire

// ===== design/sensor_twowire_register_slave.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// R1 - Host masters the bus, bytes, slow clock
// R2 - Every byte followed by acknowledge bit
// R3 - Data changes with clock high: start/stop
// R4 - Master opens with start, ends cleanly
// R5 - Address lsb selects read or write
// R6 - Direction held until next address byte
// R7 - Valid address acknowledged, direction stored
// R8 - Write: second byte is register index
// R9 - Index msb selects auto-increment
// R10 - Auto-increment after each slave acknowledge; code steps on each written data byte and each master ack of a read
// R11 - Received byte stored at current index
// R12 - Master writes until nack or end
// R13 - Read returns index, then register contents
// R14 - Receiver acknowledges in both directions
// R15 - Index left one past last access
// R16 - Only master ends a message
// R17 - Status registers are read-only
// R18 - All registers copied into field line
// R19 - Suspend: no video, no bus traffic
// R20 - Suspend resets everything, four-field restart
// R21 - System clock runs across power changes
// R22 - Soft reset bit restores all defaults
// R23 - Low power until bit zero cleared
// R24 - Writes to reserved locations ignored
// R25 - Fixed address; mismatch ignored until start
// R26 - Index seven bits, wraps past top
module sensor_twowire_register_slave
(
    input  wire logic                                  clk,
    input  wire logic                                  rst,
    input  wire logic                                  ce,
    input  wire logic                                  scl,
    input  wire logic                                  sda_in,
    output logic                                       sda_out,
    output logic                                       sda_oe,
    input  wire logic                                  suspend,
    input  wire logic                                  field_start,
    input  wire logic [sensor_twowire_pkg::IDX_W-1:0]  snap_index,
    output logic [7:0]                                 snap_data,
    output logic [7:0]                                 power_timing_setup,
    output logic                                       low_power,
    output logic                                       video_enable
);
    import sensor_twowire_pkg::*;

    // ==========================================
    // Declarations
    twowire_link_if link ();

    state_t           state;
    logic [3:0]       meta;
    logic [3:0]       sync;
    logic             scl_d;
    logic             sda_d;
    logic             tog_d;
    logic [2:0]       bit_cnt;
    logic             byte_ready;
    logic [7:0]       shreg;
    logic [7:0]       tx_shift;
    logic             read_dir;
    logic [6:0]       index;
    logic             autoinc;
    logic [7:0]       regs [0:REG_COUNT-1];
    logic [2:0]       fields;
    logic             scl_s;
    logic             sda_s;
    logic             susp_s;
    logic             start_ev;
    logic             stop_ev;
    logic             rise_ev;
    logic             fall_ev;
    logic             act;
    logic             idx_ev;
    logic             wr_ev;
    logic             rd_ev;
    logic [7:0]       next_tx;

    twowire_bit_sampler u_sampler
    (
        .scl    (scl),
        .rst    (rst),
        .sda_in (sda_in),
        .link   (link.sampler)
    );

    // ==========================================
    // Decoding
    function automatic logic writable(input logic [6:0] idx);
        writable = (idx >= FIRST_RW_INDEX) && (idx != IDX_RESERVED); // R24
    endfunction

    function automatic logic [7:0] default_of(input logic [6:0] idx);
        case (idx)
            IDX_POWER_TIMING_SETUP:      default_of = POWER_TIMING_SETUP_DEFAULT;
            IDX_SETUP1:      default_of = SETUP1_DEFAULT;
            IDX_SYNC_VALUE:  default_of = SYNC_DEFAULT;
            IDX_PIN_MAPPING: default_of = PIN_MAP_DEFAULT;
            IDX_DATA_FORMAT: default_of = FORMAT_DEFAULT;
            default:         default_of = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] status_of(input logic [6:0] idx);
        case (idx)
            7'h00:       status_of = ID_HIGH;
            7'h01:       status_of = ID_LOW;
            IDX_STATUS0: status_of = STATUS0_DEFAULT;
            IDX_XEND_H:  status_of = XEND_H_VALUE;
            IDX_XEND_L:  status_of = XEND_L_VALUE;
            IDX_YEND_H:  status_of = YEND_H_VALUE;
            IDX_YEND_L:  status_of = YEND_L_VALUE;
            default:     status_of = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] read_byte(input logic [6:0] idx);
        if (idx <= STATUS_LAST)
            read_byte = status_of(idx); // R17
        else if (!writable(idx))
            read_byte = UNUSED_BYTE;
        else
            read_byte = regs[idx];
    endfunction

    // ==========================================
    // Pin synchronisers and events
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta  <= 4'hc;
            sync  <= 4'hc;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            tog_d <= 1'b0;
        end
        else if (ce)
        begin
            meta  <= {scl, sda_in, suspend, link.edge_toggle};
            sync  <= meta;
            scl_d <= sync[3];
            sda_d <= sync[2];
            tog_d <= sync[0];
        end
    end

    assign scl_s    = sync[3];
    assign sda_s    = sync[2];
    assign susp_s   = sync[1];
    assign start_ev = scl_s && scl_d && sda_d && !sda_s; // R3
    assign stop_ev  = scl_s && scl_d && !sda_d && sda_s; // R3
    assign rise_ev  = sync[0] ^ tog_d;
    assign fall_ev  = scl_d && !scl_s;
    assign act      = ce && fall_ev && !start_ev && !stop_ev;
    assign idx_ev   = act && byte_ready && (state == ST_INDEX);
    assign wr_ev    = act && byte_ready && (state == ST_WDATA);
    assign rd_ev    = act && (state == ST_MACK);
    assign next_tx  = (state == ST_ACK_ADDR) ? {1'b0, index} // R13
                                             : read_byte(index);

    // ==========================================
    // Protocol engine
    always_ff @(posedge clk)
    begin
        if (rst || susp_s) // R19
        begin
            state      <= ST_IDLE;
            bit_cnt    <= 3'd0;
            byte_ready <= 1'b0;
            shreg      <= 8'h00;
            tx_shift   <= 8'h00;
            read_dir   <= 1'b0;
            sda_oe     <= 1'b0;
        end
        else if (ce)
        begin
            if (start_ev)
            begin
                state      <= ST_ADDR; // R4
                bit_cnt    <= 3'd0;
                byte_ready <= 1'b0;
                sda_oe     <= 1'b0;
            end
            else if (stop_ev)
            begin
                state  <= ST_IDLE; // R16
                sda_oe <= 1'b0;
            end
            else if (rise_ev)
            begin
                case (state)
                    ST_ADDR, ST_INDEX, ST_WDATA, ST_TX:
                    begin
                        shreg      <= {shreg[6:0], link.sampled_bit}; // R2
                        bit_cnt    <= 3'(bit_cnt + 3'd1);
                        byte_ready <= (bit_cnt == 3'd7); // R1
                    end
                    ST_MACK:
                    begin
                        if (link.sampled_bit)
                            state <= ST_IGNORE; // R16
                    end
                    default:
                    begin
                    end
                endcase
            end
            else if (fall_ev)
            begin
                case (state)
                    ST_ADDR:
                    begin
                        if (byte_ready)
                        begin
                            byte_ready <= 1'b0;
                            if (shreg[7:1] == DEVICE_ADDR) // R25
                            begin
                                read_dir <= shreg[0]; // R5 R6 R7
                                sda_oe   <= 1'b1; // R7
                                state    <= ST_ACK_ADDR;
                            end
                            else
                                state <= ST_IGNORE; // R25
                        end
                    end
                    ST_ACK_ADDR, ST_MACK:
                    begin
                        if (read_dir)
                        begin
                            sda_oe   <= ~next_tx[7]; // R13 R14
                            tx_shift <= {next_tx[6:0], 1'b0};
                            state    <= ST_TX;
                        end
                        else
                        begin
                            sda_oe <= 1'b0;
                            state  <= ST_INDEX; // R8
                        end
                    end
                    ST_INDEX, ST_WDATA:
                    begin
                        if (byte_ready)
                        begin
                            byte_ready <= 1'b0;
                            sda_oe     <= 1'b1; // R14
                            state      <= (state == ST_INDEX) ? ST_ACK_INDEX
                                                              : ST_ACK_DATA;
                        end
                    end
                    ST_ACK_INDEX, ST_ACK_DATA:
                    begin
                        sda_oe <= 1'b0;
                        state  <= ST_WDATA; // R12
                    end
                    ST_TX:
                    begin
                        if (byte_ready)
                        begin
                            byte_ready <= 1'b0;
                            sda_oe     <= 1'b0; // R14
                            state      <= ST_MACK;
                        end
                        else
                        begin
                            sda_oe   <= ~tx_shift[7];
                            tx_shift <= {tx_shift[6:0], 1'b0};
                        end
                    end
                    default:
                    begin
                    end
                endcase
            end
        end
    end

    // ==========================================
    // Index register
    always_ff @(posedge clk)
    begin
        if (rst || susp_s)
        begin
            index   <= 7'h00;
            autoinc <= 1'b0;
        end
        else if (idx_ev)
        begin
            index   <= shreg[6:0]; // R8
            autoinc <= shreg[7]; // R9
        end
        else if ((wr_ev || (rd_ev && read_dir)) && autoinc)
            index <= 7'(index + 7'd1); // R10 R15 R26
    end

    // ==========================================
    // Register file
    always_ff @(posedge clk)
    begin
        if (rst || susp_s) // R20
        begin
            for (int i = 0; i < REG_COUNT; i++)
                regs[i] <= default_of(7'(i));
        end
        else if (wr_ev)
        begin
            if ((index == IDX_POWER_TIMING_SETUP) && shreg[SOFT_RESET_BIT])
            begin
                for (int i = 0; i < REG_COUNT; i++)
                    regs[i] <= default_of(7'(i)); // R22
            end
            else if (writable(index))
                regs[index] <= shreg; // R11 R24
        end
    end

    // ==========================================
    // Power, field sequence and field-line copy
    always_ff @(posedge clk)
    begin
        if (rst || susp_s)
        begin
            fields             <= 3'd0;
            video_enable       <= 1'b0;
            low_power          <= 1'b1;
            power_timing_setup <= POWER_TIMING_SETUP_DEFAULT;
            snap_data          <= 8'h00;
            sda_out            <= 1'b0;
        end
        else if (ce)
        begin
            low_power          <= regs[IDX_POWER_TIMING_SETUP][LOW_POWER_BIT]; // R23
            power_timing_setup <= regs[IDX_POWER_TIMING_SETUP];
            snap_data          <= read_byte(snap_index); // R18
            sda_out            <= 1'b0;
            if (regs[IDX_POWER_TIMING_SETUP][LOW_POWER_BIT])
                fields <= 3'd0;
            else if (field_start && (fields != POWERUP_FIELDS_V))
                fields <= 3'(fields + 3'd1); // R20
            video_enable <= !regs[IDX_POWER_TIMING_SETUP][LOW_POWER_BIT]
                            && (fields == POWERUP_FIELDS_V);
        end
    end

    // ==========================================
    // Checks
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence addr_byte_s;
        act && byte_ready && (state == ST_ADDR) && !susp_s;
    endsequence

    sequence nack_s;
        ce && rise_ev && (state == ST_MACK) && link.sampled_bit
        && !start_ev && !stop_ev && !susp_s;
    endsequence

    AST_SUSPEND_QUIET: assert property (susp_s |=> !sda_oe && !video_enable) // R19
        else $error("bus driven while suspended");
    AST_SUSPEND_RESET: assert property
        (susp_s |=> regs[IDX_POWER_TIMING_SETUP] == POWER_TIMING_SETUP_DEFAULT ##1 low_power) // R20
        else $error("suspend did not restore setup");
    AST_ADDR_ACK: assert property
        (addr_byte_s and (shreg[7:1] == DEVICE_ADDR)
         |=> sda_oe && state == ST_ACK_ADDR && read_dir == $past(shreg[0])) // R7
        else $error("own address not acknowledged");
    AST_ADDR_MISS: assert property
        (addr_byte_s and (shreg[7:1] != DEVICE_ADDR)
         |=> !sda_oe && state == ST_IGNORE) // R25
        else $error("foreign address acknowledged");
    AST_DIR_HOLD: assert property
        (!(act && state == ST_ADDR) && !susp_s |=> $stable(read_dir)) // R6
        else $error("direction changed without address");
    AST_INDEX_LOAD: assert property
        (idx_ev && !susp_s
         |=> index == $past(shreg[6:0]) && autoinc == $past(shreg[7])) // R9
        else $error("index byte not taken");
    AST_AUTOINC: assert property
        (wr_ev && autoinc && !susp_s |=> index == 7'($past(index) + 7'd1)) // R10
        else $error("index did not advance");
    AST_SOFT_RESET: assert property
        (wr_ev && !susp_s && index == IDX_POWER_TIMING_SETUP && shreg[SOFT_RESET_BIT]
         |=> regs[IDX_POWER_TIMING_SETUP] == POWER_TIMING_SETUP_DEFAULT ##1 low_power) // R22
        else $error("soft reset ignored");
    AST_NACK_END: assert property (nack_s |=> state == ST_IGNORE && !sda_oe) // R16
        else $error("transmit continued after nack");
    AST_READ_INDEX: assert property
        (act && state == ST_ACK_ADDR && read_dir && !susp_s
         |=> state == ST_TX && sda_oe) // R13
        else $error("index byte not sent first");
    AST_POWERUP: assert property
        ($rose(video_enable) |-> fields == POWERUP_FIELDS_V) // R20
        else $error("video before four fields");

endmodule

`default_nettype wire

// ===== verification/twowire_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Two-wire bus master
module twowire_host_model
#(
    parameter int Q = 165
)
(
    output logic      scl,
    output logic      sda_oe,
    input  wire logic sda
);
    initial
    begin
        scl    = 1'b1;
        sda_oe = 1'b0;
    end

    // One bit, data changed only while scl low
    task automatic bit_xfer(input logic b, output logic r);
        sda_oe = ~b;
        #Q scl = 1'b1;
        #Q r = sda;
        #Q scl = 1'b0;
        #Q;
    endtask

    task automatic start();
        sda_oe = 1'b0;
        #Q scl = 1'b1;
        #Q sda_oe = 1'b1;
        #Q scl = 1'b0;
        #Q;
    endtask

    task automatic stop();
        sda_oe = 1'b1;
        #Q scl = 1'b1;
        #Q sda_oe = 1'b0;
        #(2 * Q);
    endtask

    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_xfer(d[i], r);
        bit_xfer(1'b1, r);
        ack = ~r;
    endtask

    task automatic get_byte(output logic [7:0] d, input logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_xfer(1'b1, d[i]);
        bit_xfer(~ack, r);
    endtask
endmodule
`default_nettype wire

// ===== verification/sensor_twowire_register_slave_test.sv
`timescale 1ns/1ps
`default_nettype none
module sensor_twowire_register_slave_test;
    import sensor_twowire_pkg::*;

    logic       clk;
    logic       rst;
    logic       ce;
    logic       scl;
    logic       sda;
    logic       sda_out;
    logic       sda_oe;
    logic       host_oe;
    logic       suspend;
    logic       field_start;
    logic [6:0] snap_index;
    logic [7:0] snap_data;
    logic [7:0] power_timing_setup;
    logic       low_power;
    logic       video_enable;
    logic [7:0] idx_b;
    logic [7:0] dat_b;
    int         err_count;
    int         cmp_count;

    localparam logic [7:0] ADDR_W = {DEVICE_ADDR, 1'b0};
    localparam logic [7:0] ADDR_R = {DEVICE_ADDR, 1'b1};

    // ==========================================
    // Data line with pull-up
    assign sda = ~host_oe & (sda_oe ? sda_out : 1'b1);

    sensor_twowire_register_slave i_dut
    (
        .clk                (clk),
        .rst                (rst),
        .ce                 (ce),
        .scl                (scl),
        .sda_in             (sda),
        .sda_out            (sda_out),
        .sda_oe             (sda_oe),
        .suspend            (suspend),
        .field_start        (field_start),
        .snap_index         (snap_index),
        .snap_data          (snap_data),
        .power_timing_setup (power_timing_setup),
        .low_power          (low_power),
        .video_enable       (video_enable)
    );

    twowire_host_model i_host
    (
        .scl    (scl),
        .sda_oe (host_oe),
        .sda    (sda)
    );

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ==========================================
    // Compare and report
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL %0t byte %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL %0t bit %b expected %b", $time, got, exp);
        end
    endtask

    task automatic test_done();
        if (err_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ==========================================
    // Access tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic wr_msg(input logic [7:0] a, input logic [7:0] ix,
                          input logic [7:0] d0, input logic [7:0] d1,
                          input int n, input logic exp_ack);
        logic ack;
        i_host.start();
        i_host.put_byte(a, ack);
        chk1(ack, exp_ack);
        if (ack === 1'b1)
        begin
            i_host.put_byte(ix, ack);
            chk1(ack, 1'b1);
            for (int k = 0; k < n; k++)
            begin
                i_host.put_byte(k == 0 ? d0 : d1, ack);
                chk1(ack, 1'b1);
            end
        end
        i_host.stop();
    endtask

    task automatic rd_msg(input int n, output logic [7:0] ix,
                          output logic [7:0] dat);
        logic ack;
        i_host.start();
        i_host.put_byte(ADDR_R, ack);
        chk1(ack, 1'b1);
        i_host.get_byte(ix, n > 0);
        if (n > 0)
            i_host.get_byte(dat, 1'b0);
        i_host.stop();
    endtask

    task automatic snap_chk(input logic [6:0] ix, input logic [7:0] exp);
        cyc(1);
        snap_index = ix;
        cyc(2);
        chk8(snap_data, exp);
    endtask

    task automatic fields(input int n);
        repeat (n)
        begin
            cyc(1);
            field_start = 1'b1;
            cyc(1);
            field_start = 1'b0;
        end
    endtask

    // ==========================================
    // Main sequence
    initial
    begin
        err_count   = 0;
        cmp_count   = 0;
        rst         = 1'b1;
        ce          = 1'b1;
        suspend     = 1'b0;
        field_start = 1'b0;
        snap_index  = 7'h00;
        cyc(3);
        rst = 1'b0;
        chk1(low_power, 1'b1);
        chk8(power_timing_setup, POWER_TIMING_SETUP_DEFAULT);
        chk1(video_enable, 1'b0);
        cyc(4);
        wr_msg({DEVICE_ADDR ^ 7'h01, 1'b0}, 8'h11, 8'h77, 8'h00, 1, 1'b0);
        snap_chk(IDX_SETUP1, SETUP1_DEFAULT);
        // Auto-increment write, index retained
        wr_msg(ADDR_W, {1'b1, IDX_SETUP1}, 8'ha5, 8'h3c, 2, 1'b1);
        rd_msg(0, idx_b, dat_b);
        chk8(idx_b, {1'b0, IDX_RESERVED});
        snap_chk(IDX_SYNC_VALUE, 8'h3c);
        wr_msg(ADDR_W, {1'b0, IDX_SETUP1}, 8'h00, 8'h00, 0, 1'b1);
        rd_msg(1, idx_b, dat_b);
        chk8(idx_b, {1'b0, IDX_SETUP1});
        chk8(dat_b, 8'ha5);
        // Incremental read, index retained
        wr_msg(ADDR_W, {1'b1, IDX_SETUP1}, 8'h00, 8'h00, 0, 1'b1);
        rd_msg(1, idx_b, dat_b);
        chk8(dat_b, 8'ha5);
        rd_msg(0, idx_b, dat_b);
        chk8(idx_b, {1'b0, IDX_SYNC_VALUE});
        // No increment without the flag
        wr_msg(ADDR_W, {1'b0, IDX_SYNC_VALUE}, 8'h55, 8'h66, 2, 1'b1);
        rd_msg(1, idx_b, dat_b);
        chk8(idx_b, {1'b0, IDX_SYNC_VALUE});
        chk8(dat_b, 8'h66);
        // Reserved and read-only targets
        wr_msg(ADDR_W, {1'b0, IDX_RESERVED}, 8'h77, 8'h00, 1, 1'b1);
        rd_msg(1, idx_b, dat_b);
        chk8(dat_b, UNUSED_BYTE);
        wr_msg(ADDR_W, {1'b0, IDX_STATUS0}, 8'hff, 8'h00, 1, 1'b1);
        rd_msg(1, idx_b, dat_b);
        chk8(dat_b, STATUS0_DEFAULT);
        // Index wraps past the top
        wr_msg(ADDR_W, 8'hff, 8'h11, 8'h22, 2, 1'b1);
        rd_msg(0, idx_b, dat_b);
        chk8(idx_b, 8'h01);
        snap_chk(7'h7f, 8'h11);
        snap_chk(7'h00, ID_HIGH);
        // Clock enable low freezes the copy
        ce = 1'b0;
        snap_index = 7'h7f;
        cyc(3);
        chk8(snap_data, ID_HIGH);
        ce = 1'b1;
        // Leave low power, four fields to video
        wr_msg(ADDR_W, {1'b0, IDX_POWER_TIMING_SETUP}, 8'h08, 8'h00, 1, 1'b1);
        chk1(low_power, 1'b0);
        chk8(power_timing_setup, 8'h08);
        fields(3);
        cyc(2);
        chk1(video_enable, 1'b0);
        fields(1);
        cyc(2);
        chk1(video_enable, 1'b1);
        // Soft reset
        wr_msg(ADDR_W, {1'b0, IDX_POWER_TIMING_SETUP}, 8'h0c, 8'h00, 1, 1'b1);
        chk1(low_power, 1'b1);
        chk8(power_timing_setup, POWER_TIMING_SETUP_DEFAULT);
        chk1(video_enable, 1'b0);
        snap_chk(IDX_SYNC_VALUE, SYNC_DEFAULT);
        // Suspend
        wr_msg(ADDR_W, {1'b1, IDX_POWER_TIMING_SETUP}, 8'h08, 8'h44, 2, 1'b1);
        fields(4);
        cyc(2);
        chk1(video_enable, 1'b1);
        suspend = 1'b1;
        cyc(4);
        chk1(video_enable, 1'b0);
        wr_msg(ADDR_W, {1'b0, IDX_SETUP1}, 8'h99, 8'h00, 1, 1'b0);
        cyc(1);
        suspend = 1'b0;
        cyc(4);
        chk1(low_power, 1'b1);
        snap_chk(IDX_SETUP1, SETUP1_DEFAULT);
        test_done();
    end

    // Hang guard
    initial
    begin
        #2000000;
        err_count++;
        test_done();
    end
endmodule
`default_nettype wire
